/* File: logic/slcf_link_ctrl.sv */
// slave side control field logic: mode, sequence counts, response choice
// assumes an outer framer hands over one received control field per frame
// with address and crc verdicts, and sends the chosen reply field
//
// Contract
// - every frame carries poll/final set; replies always set final
// - snrm 93h, disc 53h, ua 73h
// - valid frame with invalid control field gets frame reject
// - reject unnumbered in nrm, numbered in ndm, unsupported, sequence loss
// - in ndm every valid unnumbered command gets ua
// - disc sends the slave to ndm or keeps it there
// - snrm in ndm enters nrm
// - snrm in nrm is invalid: reject and drop to ndm
// - buffer free: rr when idle, information frame when message pending; code answers rr instead when the frame acks its last info frame
// - no free buffer: answer rnr
// - incoming rnr never answered with an information frame
// - incoming nr checked against ns; equal is correct when all acked
// - after own info frame, nr equal ns plus one advances ns, releases
// - after own info frame, nr equal ns means resend it
// - any other nr is an irrecoverable sequence error
// - info ns equal own nr: forward message upward
// - info ns equal nr minus one: duplicate, acknowledge and discard
// - info ns otherwise: irrecoverable sequence error
// - three bit counts, arithmetic modulo eight
// - reset gives ndm; entering nrm clears both counts
// - accepted in-sequence info increments nr, reported in next field
// - address mismatch or bad crc: ignore, no reply
`timescale 1ns/1ns
module slcf_link_ctrl (
  // clock and reset
  input  wire logic                         i_core_clk,
  input  wire logic                         i_nrst,
  // apb slave
  input  wire logic                         i_psel,
  input  wire logic                         i_penable,
  input  wire logic                         i_pwrite,
  input  wire logic [slcf_pkg::ADDR_W-1:0]  i_paddr,
  input  wire logic [31:0]                  i_pwdata,
  output logic      [31:0]                  o_prdata,
  output logic                              o_pready,
  output logic                              o_pslverr,
  // received frame from the framer
  input  wire logic                         i_rx_valid,
  input  slcf_pkg::slcf_rx_s                i_rx,
  // upper layer status
  input  wire logic                         i_rx_buf_free,
  input  wire logic                         i_tx_msg_pending,
  // reply to the framer
  output logic                              o_tx_valid,
  output slcf_pkg::slcf_tx_s                o_tx,
  // upper layer events
  output logic                              o_rx_deliver,
  output logic                              o_rx_discard,
  output logic                              o_tx_release,
  output logic                              o_tx_resend,
  // link state
  output logic                              o_link_nrm
);

  // ***************************************************
  // state
  // ***************************************************
  slcf_pkg::slcf_mode_e   mode;
  slcf_pkg::slcf_mode_e   next_mode;
  slcf_pkg::slcf_dec_s    dec;
  logic [2:0]             nr;
  logic [2:0]             ns;
  logic [2:0]             next_nr;
  logic [2:0]             next_ns;
  logic                   last_info;
  logic                   next_last_info;
  logic                   link_en;
  logic                   disc_req;
  logic [slcf_pkg::EV_W-1:0] events;
  logic [slcf_pkg::EV_W-1:0] ev_set;
  logic [slcf_pkg::EV_W-1:0] ev_clr;
  logic [7:0]             last_rx;
  logic [7:0]             frmr_cnt;
  logic                   accept;
  logic [7:0]             next_ctrl;
  logic                   next_is_info;
  logic                   next_deliver;
  logic                   next_discard;
  logic                   next_release;
  logic                   next_resend;
  logic                   seq_err;
  logic                   ack_adv;
  logic [2:0]             ns_after;
  logic [2:0]             nr_after;
  logic                   apb_wr;
  logic                   apb_rd;

  slcf_ctrl_decode u_decode (
    .i_ctrl (i_rx.ctrl),
    .o_dec  (dec)
  );

  // drop frames with bad address or crc
  assign accept = i_rx_valid & i_rx.addr_ok & i_rx.crc_ok & link_en;

  // ***************************************************
  // response choice
  // ***************************************************
  always_comb begin
    next_mode      = mode;
    next_nr        = nr;
    next_ns        = ns;
    next_last_info = last_info;
    next_ctrl      = slcf_pkg::CF_FRMR;
    next_is_info   = 1'b0;
    next_deliver   = 1'b0;
    next_discard   = 1'b0;
    next_release   = 1'b0;
    next_resend    = 1'b0;
    seq_err        = 1'b0;
    ack_adv        = 1'b0;
    ns_after       = ns;
    nr_after       = nr;
    ev_set         = '0;
    if (accept) begin
      // nr field of every accepted frame, unnumbered ones included, against own ns
      if (dec.nr == ns) begin
        next_resend = last_info;
      end else if (last_info && dec.nr == 3'(ns + 3'h1)) begin
        ack_adv = 1'b1;
      end else begin
        seq_err = 1'b1;
      end
      if (dec.cls == slcf_pkg::CLS_INFO) begin
        if (dec.ns == nr) begin
          next_deliver = i_rx_buf_free;
        end else if (dec.ns == 3'(nr - 3'h1)) begin
          next_discard = 1'b1;
        end else begin
          seq_err = 1'b1;
        end
      end
      ns_after = ack_adv ? 3'(ns + 3'h1) : ns;
      nr_after = next_deliver ? 3'(nr + 3'h1) : nr;
      case (mode)
        slcf_pkg::MODE_NDM: begin
          if (dec.cls == slcf_pkg::CLS_SNRM) begin
            next_mode = slcf_pkg::MODE_NRM;
            next_nr   = slcf_pkg::SEQ_RST;
            next_ns   = slcf_pkg::SEQ_RST;
            next_ctrl = slcf_pkg::CF_UA;
          end else if (dec.cls == slcf_pkg::CLS_DISC) begin
            next_ctrl = slcf_pkg::CF_UA;
          end else begin
            // numbered or unknown frame in ndm
            next_ctrl = slcf_pkg::CF_FRMR;
          end
          next_last_info = 1'b0;
          next_deliver   = 1'b0;
          next_discard   = 1'b0;
          next_resend    = 1'b0;
          seq_err        = 1'b0;
        end
        slcf_pkg::MODE_NRM: begin
          if (dec.cls == slcf_pkg::CLS_SNRM ||
              dec.cls == slcf_pkg::CLS_DISC ||
              dec.cls == slcf_pkg::CLS_BAD || seq_err) begin
            // snrm, disc, bad field or lost sequence drop to ndm
            next_mode      = slcf_pkg::MODE_NDM;
            next_ctrl      = slcf_pkg::CF_FRMR;
            next_last_info = 1'b0;
            next_deliver   = 1'b0;
            next_discard   = 1'b0;
            next_resend    = 1'b0;
          end else begin
            next_ns      = ns_after;
            next_nr      = nr_after;
            next_release = ack_adv;
            if (!i_rx_buf_free) begin
              next_ctrl    = {nr_after, slcf_pkg::CF_RNR_LO};
              next_discard = 1'b0;
            // rnr poll never carries a message
            end else if (dec.cls == slcf_pkg::CLS_RNR) begin
              next_ctrl = {nr_after, slcf_pkg::CF_RR_LO};
            // pending message rides on the reply unless this frame acks own last info frame
            end else if (i_tx_msg_pending && !ack_adv) begin
              next_ctrl    = {nr_after, 1'b1, ns_after, 1'b0};
              next_is_info = 1'b1;
            end else begin
              next_ctrl = {nr_after, slcf_pkg::CF_RR_LO};
            end
            next_last_info = next_is_info;
            next_resend    = next_resend & next_is_info;
          end
        end
        default: begin
          next_mode = slcf_pkg::MODE_NDM;
        end
      endcase
      ev_set[slcf_pkg::EV_FRMR] = (next_ctrl == slcf_pkg::CF_FRMR);
      ev_set[slcf_pkg::EV_SEQ]  = seq_err;
      ev_set[slcf_pkg::EV_BAD]  = (dec.cls == slcf_pkg::CLS_BAD);
      ev_set[slcf_pkg::EV_RNR]  = (next_ctrl[4:0] == slcf_pkg::CF_RNR_LO) &&
                                  (mode == slcf_pkg::MODE_NRM);
    end
  end

  // ***************************************************
  // mode and sequence counts
  // ***************************************************
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      mode      <= slcf_pkg::MODE_NDM;
      nr        <= slcf_pkg::SEQ_RST;
      ns        <= slcf_pkg::SEQ_RST;
      last_info <= 1'b0;
    end else if (disc_req) begin
      // software disconnect; master will see a reject next poll
      mode      <= slcf_pkg::MODE_NDM;
      last_info <= 1'b0;
    end else begin
      mode      <= next_mode;
      nr        <= next_nr;
      ns        <= next_ns;
      last_info <= next_last_info;
    end
  end

  // ***************************************************
  // reply and upper layer strobes
  // ***************************************************
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_tx_valid   <= 1'b0;
      o_tx         <= '0;
      o_rx_deliver <= 1'b0;
      o_rx_discard <= 1'b0;
      o_tx_release <= 1'b0;
      o_tx_resend  <= 1'b0;
      o_link_nrm   <= 1'b0;
    end else begin
      // reject code chosen above is sent as is
      o_tx_valid   <= accept;
      if (accept) begin
        o_tx.ctrl    <= next_ctrl;
        o_tx.is_info <= next_is_info;
      end
      o_rx_deliver <= accept & next_deliver;
      o_rx_discard <= accept & next_discard;
      o_tx_release <= accept & next_release;
      o_tx_resend  <= accept & next_resend;
      o_link_nrm   <= disc_req ? 1'b0 : (next_mode == slcf_pkg::MODE_NRM);
    end
  end

  // ***************************************************
  // apb access
  // ***************************************************
  // zero wait states: pready is high whenever out of reset
  assign apb_wr = i_psel & i_penable & o_pready & i_pwrite;
  assign apb_rd = i_psel & ~i_penable & ~i_pwrite;

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_pready <= 1'b0;
    end else begin
      o_pready <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      link_en  <= slcf_pkg::CTRL_EN_RST;
      disc_req <= 1'b0;
    end else begin
      disc_req <= 1'b0;
      if (apb_wr && i_paddr == slcf_pkg::REG_CTRL) begin
        link_en  <= i_pwdata[slcf_pkg::CTRL_EN];
        disc_req <= i_pwdata[slcf_pkg::CTRL_DISC];
      end
    end
  end

  // write one to clear; a new event in the same cycle wins
  assign ev_clr = (apb_wr && i_paddr == slcf_pkg::REG_EVENTS) ?
                  i_pwdata[slcf_pkg::EV_W-1:0] : '0;

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      events <= '0;
    end else begin
      events <= (events & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      last_rx  <= 8'h00;
      frmr_cnt <= 8'h00;
    end else begin
      if (accept) begin
        last_rx <= i_rx.ctrl;
      end
      if (apb_wr && i_paddr == slcf_pkg::REG_COUNT) begin
        frmr_cnt <= 8'h00;
      end else if (ev_set[slcf_pkg::EV_FRMR] &&
                   frmr_cnt != slcf_pkg::CNT_MAX) begin
        // saturates so a stuck link cannot wrap to a clean look
        frmr_cnt <= 8'(frmr_cnt + 8'h01);
      end
    end
  end

  // read data sampled in setup phase, held through access
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (i_psel && !i_penable) begin
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
      case (i_paddr)
        slcf_pkg::REG_CTRL: begin
          if (apb_rd) begin
            o_prdata[slcf_pkg::CTRL_EN] <= link_en;
          end
        end
        slcf_pkg::REG_STATUS: begin
          if (apb_rd) begin
            o_prdata[0]     <= (mode == slcf_pkg::MODE_NRM);
            o_prdata[6:4]   <= nr;
            o_prdata[10:8]  <= ns;
            o_prdata[12]    <= last_info;
          end
        end
        slcf_pkg::REG_EVENTS: begin
          if (apb_rd) begin
            o_prdata[slcf_pkg::EV_W-1:0] <= events;
          end
        end
        slcf_pkg::REG_LAST: begin
          if (apb_rd) begin
            o_prdata[7:0]  <= last_rx;
            o_prdata[15:8] <= o_tx.ctrl;
          end
        end
        slcf_pkg::REG_COUNT: begin
          if (apb_rd) begin
            o_prdata[7:0] <= frmr_cnt;
          end
        end
        default: begin
          o_pslverr <= 1'b1;
        end
      endcase
    end
  end

endmodule : slcf_link_ctrl

/* File: inc/slcf_pkg.sv */
// shared constants and types of the slave link control field logic
// assumes one node clock; framing, address match and crc are done outside
package slcf_pkg;

  // ***************************************************
  // control field encodings
  // ***************************************************
  localparam logic [7:0] CF_SNRM  = 8'h93;
  localparam logic [7:0] CF_DISC  = 8'h53;
  localparam logic [7:0] CF_UA    = 8'h73;
  localparam logic [7:0] CF_FRMR  = 8'h97;
  // low five bits of supervisory fields, final bit included
  localparam logic [4:0] CF_RR_LO  = 5'h11;
  localparam logic [4:0] CF_RNR_LO = 5'h15;
  localparam int         PF_BIT    = 4;

  // ***************************************************
  // register map, byte addresses on apb
  // ***************************************************
  localparam int         ADDR_W      = 8;
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_EVENTS  = 8'h08;
  localparam logic [7:0] REG_LAST    = 8'h0c;
  localparam logic [7:0] REG_COUNT   = 8'h10;
  localparam int         CTRL_EN     = 0;
  localparam int         CTRL_DISC   = 1;
  localparam logic       CTRL_EN_RST = 1'b1;
  localparam int         EV_W        = 4;
  localparam int         EV_FRMR     = 0;
  localparam int         EV_SEQ      = 1;
  localparam int         EV_BAD      = 2;
  localparam int         EV_RNR      = 3;
  localparam logic [2:0] SEQ_RST     = 3'h0;
  localparam logic [7:0] CNT_MAX     = 8'hff;

  // ***************************************************
  // types
  // ***************************************************
  typedef enum logic [0:0] {
    MODE_NDM = 1'b0,
    MODE_NRM = 1'b1
  } slcf_mode_e;

  typedef enum logic [2:0] {
    CLS_SNRM = 3'b000,
    CLS_DISC = 3'b001,
    CLS_RR   = 3'b010,
    CLS_RNR  = 3'b011,
    CLS_INFO = 3'b100,
    CLS_BAD  = 3'b101
  } slcf_class_e;

  typedef struct packed {
    slcf_class_e cls;
    logic [2:0]  nr;
    logic [2:0]  ns;
  } slcf_dec_s;

  typedef struct packed {
    logic [7:0] ctrl;
    logic       addr_ok;
    logic       crc_ok;
  } slcf_rx_s;

  typedef struct packed {
    logic [7:0] ctrl;
    logic       is_info;
  } slcf_tx_s;

endpackage : slcf_pkg

/* File: logic/slcf_ctrl_decode.sv */
// classifier of a received control field
// purely combinational; the caller registers whatever it derives from it
`timescale 1ns/1ns
module slcf_ctrl_decode (
  // field in
  input  wire logic [7:0]        i_ctrl,
  // class and counts out
  output slcf_pkg::slcf_dec_s    o_dec
);

  // ***************************************************
  // decode
  // ***************************************************
  always_comb begin
    o_dec.nr  = i_ctrl[7:5];
    o_dec.ns  = i_ctrl[3:1];
    o_dec.cls = slcf_pkg::CLS_BAD;
    if (i_ctrl[slcf_pkg::PF_BIT]) begin
      if (!i_ctrl[0]) begin
        o_dec.cls = slcf_pkg::CLS_INFO;
      end else if (!i_ctrl[1]) begin
        if (i_ctrl[4:0] == slcf_pkg::CF_RR_LO) begin
          o_dec.cls = slcf_pkg::CLS_RR;
        end else if (i_ctrl[4:0] == slcf_pkg::CF_RNR_LO) begin
          o_dec.cls = slcf_pkg::CLS_RNR;
        end
      end else if (i_ctrl == slcf_pkg::CF_SNRM) begin
        o_dec.cls = slcf_pkg::CLS_SNRM;
      end else if (i_ctrl == slcf_pkg::CF_DISC) begin
        o_dec.cls = slcf_pkg::CLS_DISC;
      end
    end
  end

endmodule : slcf_ctrl_decode

/* File: tb/slcf_checker.sv */
// port assertions of the slave link control logic
// bound to slcf_link_ctrl; one clock, synchronous active low reset
`timescale 1ns/1ns
module slcf_checker (
  // clock and reset
  input wire logic          i_core_clk,
  input wire logic          i_nrst,
  // frame path
  input wire logic          i_rx_valid,
  input slcf_pkg::slcf_rx_s i_rx,
  input wire logic          i_rx_buf_free,
  input wire logic          o_tx_valid,
  input slcf_pkg::slcf_tx_s o_tx,
  input wire logic          o_rx_deliver,
  input wire logic          o_link_nrm
);
  logic ok;
  logic numbered;
  assign ok = i_rx_valid & i_rx.addr_ok & i_rx.crc_ok;
  // supervisory or information field, poll bit aside
  assign numbered = ~i_rx.ctrl[0] | (i_rx.ctrl[1:0] == 2'b01);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  // ***************************************************
  // properties
  // ***************************************************
  a_final_set: assert property (
    o_tx_valid |-> o_tx.ctrl[4]) else $error("reply without final bit");
  a_reply_next: assert property (
    ok |=> o_tx_valid) else $error("accepted frame not answered");
  a_bad_silent: assert property (
    i_rx_valid && !ok |=> !o_tx_valid && $stable(o_link_nrm))
    else $error("ignored frame changed state or got a reply");
  a_snrm_ndm: assert property (
    ok && i_rx.ctrl == 8'h93 && !o_link_nrm |=> o_tx.ctrl == 8'h73
    && o_link_nrm) else $error("snrm in ndm mishandled");
  a_snrm_nrm: assert property (
    ok && i_rx.ctrl == 8'h93 && o_link_nrm |=> o_tx.ctrl == 8'h97
    && !o_link_nrm) else $error("snrm in nrm mishandled");
  a_disc_ndm: assert property (
    ok && i_rx.ctrl == 8'h53 |=> !o_link_nrm
    && o_tx.ctrl == ($past(o_link_nrm) ? 8'h97 : 8'h73))
    else $error("disc mishandled");
  a_ndm_numbered: assert property (
    ok && !o_link_nrm && numbered |=> o_tx.ctrl == 8'h97)
    else $error("numbered field in ndm not rejected");
  a_rnr_no_info: assert property (
    ok && o_link_nrm && i_rx.ctrl[4:0] == 5'h15 |=> !o_tx.is_info)
    else $error("rnr poll answered with information");
  a_no_buf: assert property (
    ok && o_link_nrm && numbered && !i_rx_buf_free
    |=> o_tx.ctrl[4:0] == 5'h15 || o_tx.ctrl == 8'h97)
    else $error("no buffer but no rnr");
  a_deliver_info: assert property (
    o_rx_deliver |-> o_tx_valid && $past(i_rx.ctrl[0]) == 1'b0)
    else $error("delivery without information frame");
  c_sync: cover property (ok && i_rx.ctrl == 8'h93 && !o_link_nrm);
  c_deliver: cover property (o_rx_deliver);
  c_reject: cover property (o_tx_valid && o_tx.ctrl == 8'h97);
endmodule : slcf_checker

/* File: tb/slcf_master_model.sv */
// bus master side: hands one control field per call to the slave logic
// the caller picks the field; reply timing is judged by the bench
`timescale 1ns/1ns
module slcf_master_model (
  // clock
  input  wire logic          i_core_clk,
  // frame towards the slave
  output logic               o_rx_valid,
  output slcf_pkg::slcf_rx_s o_rx
);
  logic busy;
  initial begin
    busy = 1'b0;
    o_rx_valid = 1'b0;
    o_rx = '0;
  end
  // idle field toggles so a stale value is never mistaken for a frame
  always @(posedge i_core_clk) begin
    if (!busy) begin
      o_rx.ctrl <= ~o_rx.ctrl;
    end
  end
  task automatic send(input logic [7:0] c, input logic aok, input logic cok);
    // claimed before the edge so the idle toggle never meets the frame
    busy = 1'b1;
    @(posedge i_core_clk);
    o_rx_valid <= 1'b1;
    o_rx <= '{ctrl: c, addr_ok: aok, crc_ok: cok};
    @(posedge i_core_clk);
    o_rx_valid <= 1'b0;
    busy = 1'b0;
  endtask : send
endmodule : slcf_master_model

/* File: tb/tb_serial_link_slave_control_field_logic.sv */
// self-checking bench of the slave link control field logic
// one reply a cycle after each accepted frame; apb answers without waits
`timescale 1ns/1ns
module tb_serial_link_slave_control_field_logic;
  logic               core_clk;
  logic               nrst;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [7:0]         paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               rx_valid;
  slcf_pkg::slcf_rx_s rx;
  logic               buf_free;
  logic               pend;
  logic               tx_valid;
  slcf_pkg::slcf_tx_s tx;
  wire  [3:0]         stb;
  logic               nrm;
  int                 err_total;
  int                 n_compared;
  logic [32:0]        stash;

  slcf_master_model master (.i_core_clk(core_clk), .o_rx_valid(rx_valid),
    .o_rx(rx));
  slcf_link_ctrl dut (.i_core_clk(core_clk), .i_nrst(nrst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_rx_valid(rx_valid), .i_rx(rx),
    .i_rx_buf_free(buf_free), .i_tx_msg_pending(pend),
    .o_tx_valid(tx_valid), .o_tx(tx), .o_rx_deliver(stb[3]),
    .o_rx_discard(stb[2]), .o_tx_release(stb[1]), .o_tx_resend(stb[0]),
    .o_link_nrm(nrm));

  always #25 core_clk = ~core_clk;

  task automatic wrap_up();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [32:0] r);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    for (n = 0; n < 8; n++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (n == 8) begin
      err_total++;
      wrap_up();
    end
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [32:0] exp);
    logic [32:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask : rd

  // one frame: field, {buffer free, pending}, reply, mode, strobes
  task automatic step(input logic [7:0] c, input logic [1:0] bp,
                      input logic [7:0] e, input logic m,
                      input logic [3:0] s);
    @(posedge core_clk);
    buf_free <= bp[1];
    pend <= bp[0];
    master.send(c, 1'b1, 1'b1);
    @(negedge core_clk);
    chk({tx_valid, tx.ctrl, tx.is_info, nrm, stb}, {1'b1, e, ~e[0], m, s});
  endtask : step

  task automatic t_sync();
    rd(8'h00, 33'h1);
    rd(8'h04, 33'h0);
    rd(8'h14, 33'h1_0000_0000);
    step(8'h11, 2'b10, 8'h97, 1'b0, 4'h0);
    step(8'h53, 2'b10, 8'h73, 1'b0, 4'h0);
    step(8'h93, 2'b10, 8'h73, 1'b1, 4'h0);
    step(8'h11, 2'b10, 8'h11, 1'b1, 4'h0);
    rd(8'h04, 33'h1);
    step(8'h53, 2'b10, 8'h97, 1'b0, 4'h0);
    step(8'h53, 2'b10, 8'h73, 1'b0, 4'h0);
    step(8'h93, 2'b10, 8'h73, 1'b1, 4'h0);
    step(8'h93, 2'b10, 8'h97, 1'b0, 4'h0);
    step(8'h53, 2'b10, 8'h73, 1'b0, 4'h0);
    step(8'h93, 2'b10, 8'h73, 1'b1, 4'h0);
    $display("test sync done");
  endtask : t_sync

  task automatic t_msgs();
    step(8'h10, 2'b00, 8'h15, 1'b1, 4'h0);
    step(8'h10, 2'b10, 8'h31, 1'b1, 4'h8);
    step(8'h10, 2'b10, 8'h31, 1'b1, 4'h4);
    step(8'h15, 2'b11, 8'h31, 1'b1, 4'h0);
    step(8'h11, 2'b11, 8'h30, 1'b1, 4'h0);
    step(8'h11, 2'b11, 8'h30, 1'b1, 4'h1);
    step(8'h31, 2'b11, 8'h31, 1'b1, 4'h2);
    step(8'h31, 2'b10, 8'h31, 1'b1, 4'h0);
    for (int k = 0; k < 2; k++) begin
      master.send(8'h93, k[0], ~k[0]);
      @(negedge core_clk);
      chk({tx_valid, nrm}, 2'b01);
    end
    $display("test messages done");
  endtask : t_msgs

  task automatic t_seq();
    step(8'h71, 2'b10, 8'h97, 1'b0, 4'h0);
    step(8'h53, 2'b10, 8'h73, 1'b0, 4'h0);
    step(8'h93, 2'b10, 8'h73, 1'b1, 4'h0);
    step(8'h1a, 2'b10, 8'h97, 1'b0, 4'h0);
    step(8'h53, 2'b10, 8'h73, 1'b0, 4'h0);
    step(8'h93, 2'b10, 8'h73, 1'b1, 4'h0);
    // eight in-sequence messages, the last one wraps the count
    for (logic [3:0] k = 0; k < 8; k++) begin
      step({4'h1, k[2:0], 1'b0}, 2'b10, {k[2:0] + 3'h1, 5'h11}, 1'b1,
           4'h8);
    end
    step(8'h01, 2'b10, 8'h97, 1'b0, 4'h0);
    step(8'hff, 2'b10, 8'h97, 1'b0, 4'h0);
    // last fields and seven rejects so far
    rd(8'h0c, 33'h97ff);
    rd(8'h10, 33'h7);
    apb(1'b1, 8'h10, 32'h0, stash);
    rd(8'h10, 33'h0);
    rd(8'h08, 33'hf);
    apb(1'b1, 8'h08, 32'hf, stash);
    rd(8'h08, 33'h0);
    step(8'h53, 2'b10, 8'h73, 1'b0, 4'h0);
    step(8'h93, 2'b10, 8'h73, 1'b1, 4'h0);
    // software disconnect forces ndm, enable stays set
    apb(1'b1, 8'h00, 32'h3, stash);
    rd(8'h00, 33'h1);
    rd(8'h04, 33'h0);
    step(8'h11, 2'b10, 8'h97, 1'b0, 4'h0);
    $display("test sequence done");
  endtask : t_seq

  initial begin
    core_clk = 1'b0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    buf_free = 1'b1;
    pend = 1'b0;
    err_total = 0;
    n_compared = 0;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    t_sync();
    t_msgs();
    t_seq();
    wrap_up();
  end
endmodule : tb_serial_link_slave_control_field_logic

bind slcf_link_ctrl slcf_checker u_chk (.i_core_clk, .i_nrst, .i_rx_valid,
  .i_rx, .i_rx_buf_free, .o_tx_valid, .o_tx, .o_rx_deliver, .o_link_nrm);
